/* File: tnr_ctrl.sv */
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "tnr_consts.svh"
// How it works
// - centre frequency is a 32-bit word, msb bit 31, rate = word/2^32 of input rate
// - frequency write loads holding only; active moves on strobe or enabled sync
// - phase offset is 8 bits, bits 7..0, msb bit 7, spans one input period
// - phase write loads holding only; active moves on strobe or enabled sync
// - any write to frequency strobe copies held frequency to active
// - any write to phase strobe copies held phase to active
// - pulse delay bits 11..4 space extra outputs; 0 and 1 invalid
// - interpolate by two gives one extra output, by four gives three
// - delay below 16 lets next sample cut a transfer short; flagged
// - bypass bit 3 skips the whole resampling section including halfbands
// - mode codes 001 010 011 110 111 valid; 000 100 101 invalid
// - every word and strobe is captured on the back-end clock
// - enabled sync loads frequency and phase; load-zero clears accumulator feedback
module tnr_ctrl
  import tnr_pkg::*;
#(
  parameter int FREQ_W  = 32,
  parameter int PHASE_W = 8,
  parameter int DELAY_W = 8
) (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               sys_rst_i,
  // apb slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // back-end events
  input  wire logic               timing_sync_input_i,
  input  wire logic               sample_in_i,
  // oscillator side
  output tnr_nco_t                nco_o,
  output logic                    accum_zero_o,
  output logic                    accum_clear_o,
  // resampler side
  output tnr_resamp_t             resamp_o,
  output logic                    out_pulse_o,
  output logic                    preempt_o
);

  // widths are tied to the fixed register layout, refused at elaboration
  if (FREQ_W != 32 || PHASE_W != 8 || DELAY_W != 8) begin : g_width_chk
    $error("tnr_ctrl: field widths are fixed by the register layout");
  end

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // valid filter mode codes
  function automatic logic mode_ok(input logic [2:0] m);
    case (m)
      3'h1, 3'h2, 3'h3, 3'h6, 3'h7: mode_ok = 1'b1;
      default:                      mode_ok = 1'b0;
    endcase
  endfunction : mode_ok

  // number of extra outputs per input sample
  // mode 001 runs the resampler alone, so it adds no extra outputs
  function automatic logic [1:0] extra_count(input logic [2:0] m);
    case (m)
      3'h2, 3'h3: extra_count = 2'h1;
      3'h6, 3'h7: extra_count = 2'h3;
      default:    extra_count = 2'h0;
    endcase
  endfunction : extra_count

  //////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state, then completion

  logic              wr_en;
  logic              rd_en;
  logic              addr_hit;
  logic [31:0]       rd_mux;
  logic [FREQ_W-1:0] freq_hold_reg;
  logic [PHASE_W-1:0] phase_hold_reg;
  logic [11:0]       rc_reg;
  logic [5:0]        tc_reg;

  assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_en = psel_i & penable_i & pready_o & ~pwrite_i;

  // pready rises one cycle into the access phase
  // registered ready costs a cycle but keeps decode off the bus path
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= psel_i & penable_i & ~pready_o;
    end
  end

  // address map, strobes read as zero
  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (paddr_i)
      `TNR_OFF_FREQ_HOLD:  rd_mux = freq_hold_reg;
      `TNR_OFF_PHASE_HOLD: rd_mux = {24'h00_0000, phase_hold_reg};
      `TNR_OFF_FREQ_STB:   rd_mux = 32'h0000_0000;
      `TNR_OFF_PHASE_STB:  rd_mux = 32'h0000_0000;
      `TNR_OFF_RESAMP_CTL: rd_mux = {20'h0_0000, rc_reg};
      `TNR_OFF_TIMING_CFG: rd_mux = {26'h000_0000, tc_reg};
      `TNR_OFF_STATUS:     rd_mux = {27'h000_0000, preempt_o, resamp_o.delay_valid,
                                     resamp_o.mode_valid, accum_clear_o, out_pulse_o};
      `TNR_OFF_FREQ_ACT:   rd_mux = nco_o.freq;
      `TNR_OFF_PHASE_ACT:  rd_mux = {24'h00_0000, nco_o.phase};
      default:             addr_hit = 1'b0;
    endcase
  end

  // read data and error are presented with pready
  // zero outside the answer cycle so stale words never leak
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i & penable_i & ~pready_o) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
      pslverr_o <= ~addr_hit;
    end else begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control words, all on the back-end clock
  // strobes carry no data; any completed write to them is the event

  logic wr_freq_hold;
  logic wr_phase_hold;
  logic wr_freq_stb;
  logic wr_phase_stb;
  logic ext_load;

  assign wr_freq_hold  = wr_en & (paddr_i == `TNR_OFF_FREQ_HOLD);
  assign wr_phase_hold = wr_en & (paddr_i == `TNR_OFF_PHASE_HOLD);
  assign wr_freq_stb   = wr_en & (paddr_i == `TNR_OFF_FREQ_STB);  // data ignored
  assign wr_phase_stb  = wr_en & (paddr_i == `TNR_OFF_PHASE_STB); // data ignored
  assign ext_load      = timing_sync_input_i & tc_reg[`TNR_TC_EXT_SYNC_BIT];

  // holding registers; reserved bits dropped
  // readable so software can check what the next strobe will load
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      freq_hold_reg  <= 32'h0000_0000;
      phase_hold_reg <= 8'h00;
    end else begin
      if (wr_freq_hold) begin
        freq_hold_reg <= pwdata_i[31:0];
      end
      if (wr_phase_hold) begin
        phase_hold_reg <= pwdata_i[7:0];
      end
    end
  end

  // resampler and timing configuration words
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rc_reg <= `TNR_RST_RC;
      tc_reg <= `TNR_RST_TC;
    end else begin
      if (wr_en & (paddr_i == `TNR_OFF_RESAMP_CTL)) begin
        rc_reg <= pwdata_i[11:0];
      end
      if (wr_en & (paddr_i == `TNR_OFF_TIMING_CFG)) begin
        tc_reg <= pwdata_i[5:0];
      end
    end
  end

  // active oscillator words move only on strobe or enabled sync
  // sync is a level: every enabled high cycle reloads both words
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      nco_o <= '0;
    end else begin
      if (wr_freq_stb | ext_load) begin
        nco_o.freq <= freq_hold_reg;
      end
      if (wr_phase_stb | ext_load) begin
        nco_o.phase <= phase_hold_reg;
      end
    end
  end

  // feedback zeroing pulse alongside a frequency load
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      accum_zero_o  <= 1'b0;
      accum_clear_o <= 1'b0;
    end else begin
      accum_zero_o  <= (wr_freq_stb | ext_load) & tc_reg[`TNR_TC_LOAD_ZERO_BIT];
      accum_clear_o <= tc_reg[`TNR_TC_CLR_ACC_BIT];
    end
  end

  // decoded resampler settings
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      resamp_o        <= '0;
      resamp_o.bypass <= 1'b1; // matches the control word's reset value
    end else begin
      resamp_o.pulse_delay <= rc_reg[`TNR_RC_DELAY_LSB +: 8];
      resamp_o.bypass      <= rc_reg[`TNR_RC_BYPASS_BIT];
      resamp_o.mode        <= rc_reg[`TNR_RC_MODE_LSB +: 3];
      resamp_o.mode_valid  <= mode_ok(rc_reg[2:0]);
      resamp_o.delay_valid <= rc_reg[11:4] >= `TNR_MIN_DELAY;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interpolation output pulse sequencer

  tnr_state_t   state_reg;
  logic [7:0]   space_cnt_reg;
  logic [1:0]   left_reg;
  logic         run_ok;
  logic [1:0]   extras;

  // invalid mode or delay stops extras; bypass passes samples straight
  assign extras = extra_count(resamp_o.mode);
  assign run_ok = resamp_o.mode_valid & resamp_o.delay_valid;

  // a new sample restarts the sequence, cutting short any remaining extras
  // limitation: a delay changed mid-train applies to the running count
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg     <= TNR_IDLE;
      space_cnt_reg <= 8'h00;
      left_reg      <= 2'h0;
    end else begin
      case (state_reg)
        TNR_IDLE: begin
          if (sample_in_i & ~resamp_o.bypass & run_ok & (extras != 2'h0)) begin
            state_reg     <= TNR_SPACE;
            space_cnt_reg <= 8'h01;
            left_reg      <= extras;
          end
        end
        TNR_SPACE: begin
          if (resamp_o.bypass | ~run_ok | (extras == 2'h0)) begin
            state_reg <= TNR_IDLE; // settings left interpolation mid-train
          end else if (sample_in_i) begin
            space_cnt_reg <= 8'h01;
            left_reg      <= extras;
          end else if (space_cnt_reg == resamp_o.pulse_delay) begin
            space_cnt_reg <= 8'h01;
            left_reg      <= left_reg - 2'h1;
            if (left_reg == 2'h1) begin
              state_reg <= TNR_IDLE;
            end
          end else begin
            space_cnt_reg <= space_cnt_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= TNR_IDLE;
        end
      endcase
    end
  end

  // pulse for each first and extra output
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_pulse_o <= 1'b0;
    end else if (resamp_o.bypass) begin
      out_pulse_o <= sample_in_i;
    end else begin
      // extras only while the settings still ask for them
      out_pulse_o <= (sample_in_i & run_ok) |
                     ((state_reg == TNR_SPACE) & ~sample_in_i & run_ok & (extras != 2'h0) &
                      (space_cnt_reg == resamp_o.pulse_delay));
    end
  end

  // short spacing may preempt the serial output
  // advisory only: the serial formatter lies outside this block
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      preempt_o <= 1'b0;
    end else begin
      preempt_o <= ~resamp_o.bypass & (extras != 2'h0) &
                   (resamp_o.pulse_delay < `TNR_SHORT_DELAY);
    end
  end

endmodule : tnr_ctrl
`default_nettype wire

/* File: tnr_consts.svh */
`ifndef TNR_CONSTS_SVH
`define TNR_CONSTS_SVH
// register byte offsets
`define TNR_OFF_FREQ_HOLD   8'h00
`define TNR_OFF_PHASE_HOLD  8'h04
`define TNR_OFF_FREQ_STB    8'h08
`define TNR_OFF_PHASE_STB   8'h0c
`define TNR_OFF_RESAMP_CTL  8'h10
`define TNR_OFF_TIMING_CFG  8'h14
`define TNR_OFF_STATUS      8'h18
`define TNR_OFF_FREQ_ACT    8'h1c
`define TNR_OFF_PHASE_ACT   8'h20
// resampler control fields
`define TNR_RC_DELAY_LSB    4
`define TNR_RC_BYPASS_BIT   3
`define TNR_RC_MODE_LSB     0
// timing configuration fields
`define TNR_TC_EXT_SYNC_BIT 5
`define TNR_TC_CLR_ACC_BIT  1
`define TNR_TC_LOAD_ZERO_BIT 0
// reset values
`define TNR_RST_RC          12'h008
`define TNR_RST_TC          6'h00
// timing figures
`define TNR_CLK_MHZ         50
`define TNR_SHORT_DELAY     8'h10
`define TNR_MIN_DELAY       8'h02
`endif

/* File: tnr_pkg.sv */
`default_nettype none
package tnr_pkg;
  // active oscillator words
  typedef struct packed {
    logic [31:0] freq;
    logic [7:0]  phase;
  } tnr_nco_t;
  // resampler settings as delivered to the filter
  typedef struct packed {
    logic [7:0] pulse_delay;
    logic       bypass;
    logic [2:0] mode;
    logic       mode_valid;
    logic       delay_valid;
  } tnr_resamp_t;
  // interpolation pulse sequencer
  typedef enum logic [1:0] {
    TNR_IDLE  = 2'b01,
    TNR_SPACE = 2'b10
  } tnr_state_t;
endpackage : tnr_pkg
`default_nettype wire

/* File: tnr_ctrl_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module tnr_ctrl_sva
  import tnr_pkg::*;
(
  // clock, reset, bus
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // events and results
  input wire logic        timing_sync_input_i,
  input wire logic        sample_in_i,
  input wire tnr_nco_t    nco_o,
  input wire logic        accum_zero_o,
  input wire tnr_resamp_t resamp_o,
  input wire logic        out_pulse_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // completed strobe writes
  wire fstb = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h08;
  wire pstb = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h0c;
  ////////////////////////////////////////
  bus_wait_a: assert property (
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("bus wait state wrong");
  bad_addr_a: assert property (
    psel_i && penable_i && !pready_o && paddr_i > 8'h20 |=> pslverr_o)
    else $error("unmapped access not refused");
  freq_hold_a: assert property (
    $changed(nco_o.freq) |-> $past(fstb) || $past(timing_sync_input_i))
    else $error("freq moved alone");
  phase_hold_a: assert property (
    $changed(nco_o.phase) |-> $past(pstb) || $past(timing_sync_input_i))
    else $error("phase moved alone");
  zero_src_a: assert property (
    accum_zero_o |-> $past(fstb) || $past(timing_sync_input_i))
    else $error("stray zero pulse");
  bypass_pass_a: assert property (
    resamp_o.bypass && sample_in_i |=> out_pulse_o)
    else $error("bypass lost a sample");
  mode_code_a: assert property (
    resamp_o.mode_valid == (resamp_o.mode inside {3'b001, 3'b010, 3'b011, 3'b110, 3'b111}))
    else $error("mode decode");
  delay_min_a: assert property (
    resamp_o.delay_valid == (resamp_o.pulse_delay > 8'h01))
    else $error("delay decode");
  no_pulse_a: assert property (
    !resamp_o.bypass && !resamp_o.mode_valid [*2] |-> !out_pulse_o)
    else $error("pulse in invalid mode");
endmodule : tnr_ctrl_sva
bind tnr_ctrl tnr_ctrl_sva chk_i (.clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pready_o, .pslverr_o, .timing_sync_input_i, .sample_in_i, .nco_o,
  .accum_zero_o, .resamp_o, .out_pulse_o);
`default_nettype wire

/* File: tb_tnr_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_tnr_ctrl;
  import tnr_pkg::*;
  logic        clk, rst, psel, pen, pwr, sync, smp, rdy, err, az, ac, pulse, pre, re;
  logic [7:0]  paddr;
  logic [31:0] wd, prd, rd;
  tnr_nco_t    numeric_oscillator;
  tnr_resamp_t rs;
  int          bad_count, compares, zc;
  logic [7:0]  vm = 8'hce;
  // one more than the programmed delay; the delay itself is the clocks between interpolated outputs
  localparam int OUT_DIV = 17;
  logic [7:0]  dl [4] = '{8'h00, 8'h01, 8'h02, 8'hff};
  tnr_ctrl dut (.clk_sys_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(wd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .timing_sync_input_i(sync), .sample_in_i(smp), .nco_o(numeric_oscillator),
    .accum_zero_o(az), .accum_clear_o(ac), .resamp_o(rs), .out_pulse_o(pulse),
    .preempt_o(pre));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // feedback-zero pulses seen so far
  always @(posedge clk) if (az === 1'b1) zc++;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // one apb transfer; never assumes the wait count, bounded instead
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    rd = prd;
    re = err;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      wrap_up();
    end
  endtask : xfer
  // sync held high for one edge
  task automatic pulse_sync;
    @(posedge clk);
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_sync
  // one input sample, then count output pulses and their spacing
  task automatic burst(input logic [11:0] rc, input int n_exp);
    int np;
    int gap;
    np = 0;
    gap = 0;
    xfer(1'b1, 8'h10, {20'h0, rc});
    @(posedge clk);
    smp <= 1'b1;
    @(posedge clk);
    smp <= 1'b0;
    repeat (60) begin
      @(posedge clk);
      gap++;
      if (pulse === 1'b1) begin
        if (np > 0) chk(gap, rc[11:4]);
        np++;
        gap = 0;
      end
    end
    chk(np, n_exp);
  endtask : burst
  ////////////////////////////////////////
  initial begin
    {rst, psel, pen, pwr, sync, smp, paddr, wd} = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h8);
    chk(numeric_oscillator, 40'h0);
    // frequency goes to holding first, active only on strobe
    xfer(1'b1, 8'h00, 32'h89abcdef);
    repeat (3) @(posedge clk);
    chk(numeric_oscillator.freq, 32'h0);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h89abcdef);
    xfer(1'b1, 8'h08, 32'hdeadbeef);
    repeat (2) @(posedge clk);
    chk(numeric_oscillator.freq, 32'h89abcdef);
    xfer(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h89abcdef);
    // phase, with reserved bits set
    xfer(1'b1, 8'h04, 32'hffffff5a);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h5a);
    chk(numeric_oscillator.phase, 8'h0);
    xfer(1'b1, 8'h0c, 32'h0);
    repeat (2) @(posedge clk);
    chk(numeric_oscillator.phase, 8'h5a);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h5a);
    // sync ignored until enabled, then loads both
    xfer(1'b1, 8'h00, 32'h123);
    xfer(1'b1, 8'h04, 32'ha5);
    pulse_sync();
    chk(numeric_oscillator, {32'h89abcdef, 8'h5a});
    xfer(1'b1, 8'h14, 32'h21);
    pulse_sync();
    chk(numeric_oscillator, {32'h123, 8'ha5});
    chk(zc, 1);
    // feedback clear level follows its configuration bit
    xfer(1'b1, 8'h14, 32'h2);
    repeat (2) @(posedge clk);
    chk(ac, 1'b1);
    // refused and write-only places
    xfer(1'b0, 8'h40, 32'h0);
    chk({re, rd}, 33'h1_0000_0000);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    // every mode code, then delay boundaries
    for (int m = 0; m < 8; m++) begin
      xfer(1'b1, 8'h10, 32'h50 | m);
      repeat (2) @(posedge clk);
      chk(rs.mode_valid, vm[m]);
      chk(rs.mode, m);
    end
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'h10, {20'h0, dl[i], 4'h1});
      repeat (2) @(posedge clk);
      chk(rs.delay_valid, dl[i] > 8'h01);
    end
    // pulse trains per mode; delays kept at 5 or more, except 0 in bypass
    burst(12'h008, 1);
    chk(rs.bypass, 1'b1);
    burst(12'h051, 1);
    burst(12'h053, 2);
    chk(pre, 1'b1);
    xfer(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h1e);
    burst({8'(OUT_DIV - 1), 4'h6}, 4);
    chk(pre, 1'b0);
    burst(12'h050, 0);
    wrap_up();
  end
endmodule : tb_tnr_ctrl
`default_nettype wire
